/* File: rtl/cpu_core_consts.vh */
// opcode, field and condition constants for the instruction core
`ifndef CPU_CORE_CONSTS_VH
`define CPU_CORE_CONSTS_VH
// first-word fields
`define F_OP 15:10
`define F_LONG 9
`define F_VAR 8
`define F_RD 7:4
`define F_RS 3:0
`define F_TRAP 6:0
// second-word fields
`define F_SBIT 7:4
`define F_DBIT 3:0
`define F_BLOG 9:8
`define F_MASK 15:8
`define F_DATA 7:0
`define F_PAGE 9:0
// opcodes
`define OP_ADD 6'h00
`define OP_ADDC 6'h01
`define OP_SUB 6'h02
`define OP_SUBC 6'h03
`define OP_AND 6'h04
`define OP_OR 6'h05
`define OP_XOR 6'h06
`define OP_MUL 6'h07
`define OP_DIV 6'h08
`define OP_DIVL 6'h09
`define OP_CPL 6'h0a
`define OP_NEG 6'h0b
`define OP_BMOV 6'h0c
`define OP_BLOG 6'h0d
`define OP_BFLD 6'h0e
`define OP_CMPD 6'h0f
`define OP_CMPI 6'h10
`define OP_NORMALIZE_COUNT_OP 6'h11
`define OP_SHIFT 6'h12
`define OP_ARITHMETIC_RIGHT_SHIFT 6'h13
`define OP_MOVX 6'h14
`define OP_JMP 6'h15
`define OP_JB 6'h16
`define OP_PUSH_AND_CALL 6'h17
`define OP_TRAP 6'h18
`define OP_SWITCH_CONTEXT_OP 6'h19
`define OP_RET 6'h1a
`define OP_EXTP 6'h1b
`define OP_NOP 6'h1c
`define OP_MOV 6'h1d
// bit logic selectors
`define BL_AND 2'h0
`define BL_OR 2'h1
`define BL_XOR 2'h2
// jump modes
`define JM_ABS 2'h0
`define JM_IND 2'h1
`define JM_REL 2'h2
// condition codes
`define CC_UC 4'h0
`define CC_Z 4'h1
`define CC_NZ 4'h2
`define CC_C 4'h3
`define CC_NC 4'h4
`define CC_N 4'h5
`define CC_NN 4'h6
`define CC_V 4'h7
// flag positions
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
// pc values
`define RESET_PC 16'h0000
`define STEP_SHORT 16'h0002
`define STEP_LONG 16'h0004
`endif

/* File: rtl/cpu_instruction_set_core.v */
// 16-bit instruction decode and execute core
// Summary of operation
// RQ1 - add/subtract word or byte, optional carry, two or four bytes
// RQ2 - signed/unsigned 16x16 multiply of two registers
// RQ3 - signed/unsigned divide of muldiv low half by a register
// RQ4 - signed/unsigned 32/16 long divide of muldiv pair by a register
// RQ5 - complement or negate a word or byte register in place
// RQ6 - AND, OR, XOR on word or byte operands
// RQ7 - copy a bit, optionally inverted, into another bit
// RQ8 - combine two bits with AND, OR or XOR into destination
// RQ9 - masked immediate modify of high or low byte of a word
// RQ10 - compare word to register, then decrement register by one or two
// RQ11 - compare word to register, then increment register by one or two
// RQ12 - count shifts needed to normalize a register, store in another
// RQ13 - logical shift left or right of a register
// RQ14 - arithmetic shift right keeping the sign bit
// RQ15 - move byte into word with sign or zero extension
// RQ16 - jump absolute, indirect or relative when condition holds
// RQ17 - relative branch when bit is set, optionally clearing it
// RQ18 - push a register, then call absolute subroutine
// RQ19 - enter service routine by immediate trap number
// RQ20 - push a register, then load it with a new word
// RQ21 - near return, optionally popping a register as well
// RQ22 - page override prefix, optionally with register extension
// RQ23 - decide two or four byte length from opcode before issue
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_instruction_set_core #(
    parameter NGPR = 16,
    parameter SPW = 4
) (
    input wire clk,
    input wire reset,
    input wire [15:0] progData,
    input wire progValid,
    output reg progRd_q,
    output reg [15:0] progAddr_q,
    output reg [15:0] pc_q,
    output reg [3:0] flags_q,
    output reg [15:0] mdh_q,
    output reg [15:0] mdl_q,
    output reg pageActive_q,
    output reg [9:0] pageNum_q,
    output reg extReg_q,
    output reg trapTaken_q
);
    localparam S_F0 = 3'd0;
    localparam S_F1 = 3'd1;
    localparam S_EX = 3'd2;
    localparam S_PUSH2 = 3'd3;
    localparam S_POP2 = 3'd4;
    reg [15:0] general_purpose_register [0:NGPR-1];
    reg [15:0] stk [0:(1<<SPW)-1];
    reg [2:0] state_q, state_d;
    reg [15:0] w0_q, w1_q, pushVal_q, pushVal_d;
    reg [SPW-1:0] sp_q, sp_d;
    reg [1:0] pageCnt_q, pageCnt_d;
    reg [15:0] pc_d, mdh_d, mdl_d, gData, sData;
    reg [3:0] flags_d, gIdx;
    reg pageActive_d, extReg_d, trap_d, gWe, sWe;
    reg [9:0] pageNum_d;
    reg [31:0] prod, quot, rem, shWide;
    reg [15:0] xIn, yAl, yIn, lres, shRes, bitWord;
    reg [16:0] sum17;
    reg [4:0] prio;
    reg cBit, isSub, bitVal, shC;
    integer i;
    // length comes from the opcode, or from the long bit for ops of no fixed length; fixed ops ignore the long bit
    function isLong;
        input [15:0] w;
        begin
            case (w[`F_OP])
                `OP_BMOV, `OP_BLOG, `OP_BFLD, `OP_JMP, `OP_JB, `OP_PUSH_AND_CALL, `OP_SWITCH_CONTEXT_OP: isLong = 1'b1; // RQ23
                `OP_MUL, `OP_DIV, `OP_DIVL, `OP_CPL, `OP_NEG, `OP_NORMALIZE_COUNT_OP, `OP_SHIFT, `OP_ARITHMETIC_RIGHT_SHIFT,
                `OP_TRAP, `OP_RET, `OP_NOP: isLong = 1'b0; // RQ23
                default: isLong = w[`F_LONG];
            endcase
        end
    endfunction
    wire [5:0] op = w0_q[`F_OP];
    wire [3:0] rd = w0_q[`F_RD];
    wire [3:0] rs = w0_q[`F_RS];
    wire alt = w0_q[`F_VAR];
    wire [7:0] ccTab = {flags_q[`FL_V], ~flags_q[`FL_N], flags_q[`FL_N], ~flags_q[`FL_C], flags_q[`FL_C],
                        ~flags_q[`FL_Z], flags_q[`FL_Z], 1'b1};
    wire condMet = ~rd[3] & ccTab[rd[2:0]]; // RQ16
    wire lng = isLong(w0_q);
    wire [15:0] opA = general_purpose_register[rd];
    wire [15:0] opR = general_purpose_register[rs];
    wire [15:0] opB = lng ? w1_q : opR;
    wire [15:0] nextPc = pc_q + (lng ? `STEP_LONG : `STEP_SHORT); // RQ23
    wire [15:0] topOfStack = stk[sp_q - 1'b1];
    wire [31:0] mdPair = {mdh_q, mdl_q};
    wire [31:0] dividend = (op == `OP_DIV) ? {{16{mdl_q[15] & ~alt}}, mdl_q} : mdPair;
    wire [31:0] divisor = {{16{opR[15] & ~alt}}, opR};
    wire byteOp = alt & (op <= `OP_XOR || op == `OP_CPL || op == `OP_NEG || op == `OP_MOV);
    wire [15:0] mask = byteOp ? 16'hff00 : 16'hffff;
    wire [15:0] stepped = (op == `OP_CMPD) ? opA - (alt ? 16'h0002 : 16'h0001) :
                          opA + (alt ? 16'h0002 : 16'h0001);
    wire [15:0] sext8 = {{8{opB[7]}}, opB[7:0]};
    // byte operands ride in the upper half so carry and sign fall out of one adder
    always @* begin
        isSub = (op == `OP_SUB || op == `OP_SUBC || op == `OP_CMPD || op == `OP_CMPI || op == `OP_NEG);
        xIn = (op == `OP_NEG) ? 16'h0000 : (byteOp ? {opA[7:0], 8'h00} : opA);
        yAl = (op == `OP_NEG) ? opA : opB;
        yAl = byteOp ? {yAl[7:0], 8'h00} : yAl;
        yIn = isSub ? (~yAl & mask) : yAl;
        cBit = (op == `OP_ADDC) ? flags_q[`FL_C] : (op == `OP_SUBC) ? ~flags_q[`FL_C] : isSub; // RQ1
        sum17 = {1'b0, xIn} + {1'b0, yIn} + (byteOp ? {8'h00, cBit, 8'h00} : {16'h0000, cBit}); // RQ1
        case (op)
            `OP_AND: lres = xIn & yAl; // RQ6
            `OP_OR: lres = xIn | yAl; // RQ6
            `OP_XOR: lres = xIn ^ yAl; // RQ6
            default: lres = ~xIn & mask; // RQ5
        endcase
        prod = alt ? {16'h0000, opA} * {16'h0000, opR} :
               $signed({{16{opA[15]}}, opA}) * $signed({{16{opR[15]}}, opR}); // RQ2
        quot = 32'h0000_0000;
        rem = 32'h0000_0000;
        if (opR != 16'h0000 && alt) begin
            quot = dividend / divisor; // RQ3 RQ4
            rem = dividend % divisor; // RQ3 RQ4
        end else if (opR != 16'h0000) begin
            quot = $signed(dividend) / $signed(divisor); // RQ3 RQ4
            rem = $signed(dividend) % $signed(divisor); // RQ3 RQ4
        end
        prio = 5'd0;
        for (i = 0; i < 16; i = i + 1) begin
            if (opR[i])
                prio = 5'd15 - i[4:0]; // RQ12
        end
        if (op == `OP_ARITHMETIC_RIGHT_SHIFT)
            shWide = $signed({opA, 16'h0000}) >>> rs; // RQ14
        else if (alt)
            shWide = {opA, 16'h0000} >> rs; // RQ13
        else
            shWide = {16'h0000, opA} << rs; // RQ13
        shRes = (op == `OP_ARITHMETIC_RIGHT_SHIFT || alt) ? shWide[31:16] : shWide[15:0];
        shC = (op == `OP_ARITHMETIC_RIGHT_SHIFT || alt) ? shWide[15] : shWide[16];
        bitVal = opR[w1_q[`F_SBIT]];
        bitWord = opA;
        case (w1_q[`F_BLOG])
            `BL_AND: bitWord[w1_q[`F_DBIT]] = opA[w1_q[`F_DBIT]] & bitVal; // RQ8
            `BL_OR: bitWord[w1_q[`F_DBIT]] = opA[w1_q[`F_DBIT]] | bitVal; // RQ8
            `BL_XOR: bitWord[w1_q[`F_DBIT]] = opA[w1_q[`F_DBIT]] ^ bitVal; // RQ8
            default: bitWord[w1_q[`F_DBIT]] = opA[w1_q[`F_DBIT]];
        endcase
        if (op == `OP_BMOV)
            bitWord[w1_q[`F_DBIT]] = bitVal ^ alt; // RQ7
    end
    always @* begin
        state_d = state_q;
        pc_d = pc_q;
        flags_d = flags_q;
        mdh_d = mdh_q;
        mdl_d = mdl_q;
        sp_d = sp_q;
        pushVal_d = pushVal_q;
        pageActive_d = pageActive_q;
        pageCnt_d = pageCnt_q;
        pageNum_d = pageNum_q;
        extReg_d = extReg_q;
        trap_d = 1'b0;
        gWe = 1'b0;
        gIdx = rd;
        gData = opA;
        sWe = 1'b0;
        sData = opA;
        case (state_q)
            S_EX: begin
                state_d = S_F0;
                pc_d = nextPc;
                // override lasts for the rd[1:0] count plus one instructions that follow
                if (pageActive_q) begin
                    if (pageCnt_q == 2'd0)
                        pageActive_d = 1'b0; // RQ22
                    else
                        pageCnt_d = pageCnt_q - 2'd1; // RQ22
                end
                case (op)
                    `OP_ADD, `OP_ADDC, `OP_SUB, `OP_SUBC, `OP_NEG: begin
                        gWe = 1'b1;
                        gData = byteOp ? {opA[15:8], sum17[15:8]} : sum17[15:0]; // RQ1 RQ5
                        flags_d = {(xIn[15] == yIn[15]) & (sum17[15] != xIn[15]), sum17[15],
                                   sum17[15:0] == 16'h0000, isSub ? ~sum17[16] : sum17[16]};
                    end
                    `OP_AND, `OP_OR, `OP_XOR, `OP_CPL: begin
                        gWe = 1'b1;
                        gData = byteOp ? {opA[15:8], lres[15:8]} : lres; // RQ5 RQ6
                        flags_d = {1'b0, lres[15], lres == 16'h0000, 1'b0};
                    end
                    `OP_MUL: begin
                        mdh_d = prod[31:16]; // RQ2
                        mdl_d = prod[15:0]; // RQ2
                        flags_d = {1'b0, prod[31], prod == 32'h0000_0000, 1'b0};
                    end
                    `OP_DIV, `OP_DIVL: begin
                        // divide by zero leaves the pair untouched and raises V
                        if (opR != 16'h0000) begin
                            mdl_d = quot[15:0]; // RQ3 RQ4
                            mdh_d = rem[15:0]; // RQ3 RQ4
                        end
                        flags_d = {opR == 16'h0000, quot[15], quot[15:0] == 16'h0000, 1'b0};
                    end
                    `OP_BMOV, `OP_BLOG: begin
                        gWe = 1'b1;
                        gData = bitWord; // RQ7 RQ8
                        flags_d[`FL_Z] = ~bitWord[w1_q[`F_DBIT]];
                    end
                    `OP_BFLD: begin
                        gWe = 1'b1;
                        gData = alt ? {(opA[15:8] & ~w1_q[`F_MASK]) | (w1_q[`F_DATA] & w1_q[`F_MASK]), opA[7:0]} :
                                {opA[15:8], (opA[7:0] & ~w1_q[`F_MASK]) | (w1_q[`F_DATA] & w1_q[`F_MASK])}; // RQ9
                    end
                    `OP_CMPD, `OP_CMPI: begin
                        gWe = 1'b1;
                        gData = stepped; // RQ10 RQ11
                        flags_d = {(xIn[15] == yIn[15]) & (sum17[15] != xIn[15]), sum17[15],
                                   sum17[15:0] == 16'h0000, ~sum17[16]}; // RQ10 RQ11
                    end
                    `OP_NORMALIZE_COUNT_OP: begin
                        gWe = 1'b1;
                        gData = {11'h000, prio}; // RQ12
                        flags_d[`FL_Z] = (opR == 16'h0000);
                    end
                    `OP_SHIFT, `OP_ARITHMETIC_RIGHT_SHIFT: begin
                        gWe = 1'b1;
                        gData = shRes; // RQ13 RQ14
                        flags_d = {1'b0, shRes[15], shRes == 16'h0000, shC};
                    end
                    `OP_MOVX: begin
                        gWe = 1'b1;
                        gData = alt ? {8'h00, opB[7:0]} : sext8; // RQ15
                        flags_d[`FL_Z] = (opB[7:0] == 8'h00);
                        flags_d[`FL_N] = alt ? 1'b0 : opB[7];
                    end
                    `OP_MOV: begin
                        gWe = 1'b1;
                        gData = byteOp ? {opA[15:8], opB[7:0]} : opB;
                    end
                    `OP_JMP: begin
                        if (condMet) begin
                            case (rs[1:0])
                                `JM_ABS: pc_d = w1_q; // RQ16
                                `JM_IND: pc_d = general_purpose_register[w1_q[3:0]]; // RQ16
                                `JM_REL: pc_d = nextPc + w1_q; // RQ16
                                default: pc_d = nextPc;
                            endcase
                        end
                    end
                    `OP_JB: begin
                        if (opA[rs]) begin
                            pc_d = nextPc + w1_q; // RQ17
                            gWe = alt;
                            gData = opA & ~(16'h0001 << rs); // RQ17
                        end
                    end
                    `OP_PUSH_AND_CALL, `OP_TRAP: begin
                        // two pushes take two cycles, register or flags first
                        sWe = 1'b1;
                        sData = (op == `OP_TRAP) ? {12'h000, flags_q} : opA; // RQ18 RQ19
                        sp_d = sp_q + 1'b1;
                        pushVal_d = nextPc;
                        state_d = S_PUSH2;
                        pc_d = (op == `OP_TRAP) ? {7'h00, w0_q[`F_TRAP], 2'b00} : w1_q; // RQ18 RQ19
                        trap_d = (op == `OP_TRAP);
                    end
                    `OP_SWITCH_CONTEXT_OP: begin
                        sWe = 1'b1;
                        sData = opA; // RQ20
                        sp_d = sp_q + 1'b1;
                        gWe = 1'b1;
                        gData = opB; // RQ20
                    end
                    `OP_RET: begin
                        pc_d = topOfStack; // RQ21
                        sp_d = sp_q - 1'b1;
                        if (alt)
                            state_d = S_POP2; // RQ21
                    end
                    `OP_EXTP: begin
                        pageActive_d = 1'b1; // RQ22
                        pageCnt_d = rd[1:0];
                        pageNum_d = lng ? w1_q[`F_PAGE] : opR[`F_PAGE]; // RQ22
                        extReg_d = alt;
                    end
                    default: begin
                    end
                endcase
            end
            S_PUSH2: begin
                sWe = 1'b1;
                sData = pushVal_q;
                sp_d = sp_q + 1'b1;
                state_d = S_F0;
            end
            S_POP2: begin
                gWe = 1'b1;
                gData = topOfStack; // RQ21
                sp_d = sp_q - 1'b1;
                state_d = S_F0;
            end
            default: begin
            end
        endcase
    end
    // arrays carry no reset, software must initialise registers
    always @(posedge clk) begin
        if (gWe)
            general_purpose_register[gIdx] <= gData;
        if (sWe)
            stk[sp_q] <= sData;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_F0;
            w0_q <= 16'h0000;
            w1_q <= 16'h0000;
            pushVal_q <= 16'h0000;
            sp_q <= {SPW{1'b0}};
            pageCnt_q <= 2'd0;
            progRd_q <= 1'b0;
            progAddr_q <= `RESET_PC;
            pc_q <= `RESET_PC;
            flags_q <= 4'h0;
            mdh_q <= 16'h0000;
            mdl_q <= 16'h0000;
            pageActive_q <= 1'b0;
            pageNum_q <= 10'h000;
            extReg_q <= 1'b0;
            trapTaken_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            flags_q <= flags_d;
            mdh_q <= mdh_d;
            mdl_q <= mdl_d;
            sp_q <= sp_d;
            pushVal_q <= pushVal_d;
            pageActive_q <= pageActive_d;
            pageCnt_q <= pageCnt_d;
            pageNum_q <= pageNum_d;
            extReg_q <= extReg_d;
            trapTaken_q <= trap_d;
            case (state_q)
                S_F0: begin
                    if (!progRd_q) begin
                        progRd_q <= 1'b1;
                        progAddr_q <= pc_q;
                    end else if (progValid) begin
                        progRd_q <= 1'b0;
                        w0_q <= progData;
                        state_q <= isLong(progData) ? S_F1 : S_EX; // RQ23
                    end
                end
                S_F1: begin
                    if (!progRd_q) begin
                        progRd_q <= 1'b1;
                        progAddr_q <= pc_q + `STEP_SHORT;
                    end else if (progValid) begin
                        progRd_q <= 1'b0;
                        w1_q <= progData;
                        state_q <= S_EX;
                    end
                end
                default: state_q <= state_d;
            endcase
        end
    end
endmodule // cpu_instruction_set_core

/* File: tb/cpu_instruction_set_core_checker.sv */
// assertions on fetch timing, instruction length and core state
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_instruction_set_core_checker #(
    parameter NGPR = 16,
    parameter SPW = 4
) (
    input wire clk,
    input wire reset,
    input wire [15:0] progData,
    input wire progValid,
    input wire progRd_q,
    input wire [15:0] progAddr_q,
    input wire [15:0] pc_q,
    input wire [3:0] flags_q,
    input wire [15:0] mdh_q,
    input wire [15:0] mdl_q,
    input wire pageActive_q,
    input wire [9:0] pageNum_q,
    input wire extReg_q,
    input wire trapTaken_q
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_fetchHold;
        progRd_q && !progValid |=> progRd_q && $stable(progAddr_q);
    endproperty
    a_fetchHold: assert property (p_fetchHold) else $error("fetch request moved before answer");

    property p_fetchDrop;
        progRd_q && progValid |=> !progRd_q;
    endproperty
    a_fetchDrop: assert property (p_fetchDrop) else $error("fetch request kept after answer");

    // two-byte opcode: no second word, next fetch two bytes on
    property p_shortLen;
        progRd_q && progValid && progAddr_q == pc_q && progData[15:10] == `OP_MUL
            |-> ##1 !progRd_q [*2] ##1 (progRd_q && progAddr_q == $past(pc_q, 3) + 16'h0002);
    endproperty
    a_shortLen: assert property (p_shortLen) else $error("short instruction length wrong");

    // four-byte opcode: second word fetched right after one idle cycle
    property p_longLen;
        progRd_q && progValid && progAddr_q == pc_q && progData[15:10] == `OP_JMP
            |-> ##1 !progRd_q ##1 (progRd_q && progAddr_q == pc_q + 16'h0002);
    endproperty
    a_longLen: assert property (p_longLen) else $error("long instruction second word missing");

    property p_firstFetch;
        $fell(reset) |=> progRd_q && progAddr_q == `RESET_PC;
    endproperty
    a_firstFetch: assert property (p_firstFetch) else $error("no fetch from start address");

    // pc and muldiv pair only move in execute cycles, never while fetching
    property p_pcStable;
        progRd_q |=> $stable(pc_q);
    endproperty
    a_pcStable: assert property (p_pcStable) else $error("program counter moved during fetch");

    property p_mdStable;
        progRd_q |=> $stable(mdl_q) && $stable(mdh_q);
    endproperty
    a_mdStable: assert property (p_mdStable) else $error("muldiv pair moved during fetch");

    // vector is trap number times four, below 0x200
    property p_trapVector;
        $rose(trapTaken_q) |=> !trapTaken_q ##[0:6]
            (progRd_q && progAddr_q == pc_q && pc_q[1:0] == 2'b00 && pc_q < 16'h0200);
    endproperty
    a_trapVector: assert property (p_trapVector) else $error("trap did not reach its vector");

    property p_extWithPage;
        $rose(extReg_q) |-> pageActive_q;
    endproperty
    a_extWithPage: assert property (p_extWithPage) else $error("register extension without page");

    // first edge may still see pre-reset values, hence two samples
    property p_resetState;
        disable iff (1'b0) reset && $past(reset) |-> !progRd_q && pc_q == `RESET_PC && mdl_q == 16'h0000
            && !pageActive_q && !trapTaken_q;
    endproperty
    a_resetState: assert property (p_resetState) else $error("state not cleared by reset");
endmodule // cpu_instruction_set_core_checker

bind cpu_instruction_set_core cpu_instruction_set_core_checker #(.NGPR(NGPR), .SPW(SPW)) chk (
    .clk(clk), .reset(reset), .progData(progData), .progValid(progValid), .progRd_q(progRd_q),
    .progAddr_q(progAddr_q), .pc_q(pc_q), .flags_q(flags_q), .mdh_q(mdh_q), .mdl_q(mdl_q),
    .pageActive_q(pageActive_q), .pageNum_q(pageNum_q), .extReg_q(extReg_q), .trapTaken_q(trapTaken_q)
);

/* File: tb/cpu_instruction_set_core_tb_top.sv */
// self-checking bench for the instruction core
`timescale 1ns/1ps
module cpu_instruction_set_core_tb_top;
    logic clk, reset, progValid;
    logic [15:0] progData;
    wire progRd_q, pageActive_q, extReg_q, trapTaken_q;
    wire [15:0] progAddr_q, pc_q, mdh_q, mdl_q;
    wire [3:0] flags_q;
    wire [9:0] pageNum_q;
    logic [15:0] rom [0:31];
    logic [15:0] a, b, w6, w7, ck, em, eh;
    int errorCnt, numChecks, dly, lag, p;
    // operand a, operand b, op words, check word, expected low, expected high
    logic [111:0] rows [$] = '{
        112'h1234_0f0f_0012_7000_1d1f_2143_0000,
        112'h12f0_0020_0112_7000_1d1f_1210_0000,
        112'h1234_0000_0210_0001_1d1f_1235_0000,
        112'h1234_0235_0812_7000_1d1f_0fff_0000,
        112'hffff_0001_0012_0412_1d1f_0002_0000,
        112'h0000_0001_0812_0c12_1d1f_fffd_0000,
        112'hf0f0_3c3c_1012_7000_1d1f_3030_0000,
        112'hf0f0_3c3c_1412_7000_1d1f_fcfc_0000,
        112'hf0f0_3c3c_1812_7000_1d1f_cccc_0000,
        112'hfffe_0003_1c12_7000_7000_fffa_ffff,
        112'hfffe_0003_1d12_7000_7000_fffa_0002,
        112'h0064_0007_1d1f_2102_7000_000e_0002,
        112'hfffe_0003_1c12_2402_7000_fffe_0000,
        112'h1234_0000_2810_7000_1d1f_edcb_0000,
        112'h0001_0000_2c10_7000_1d1f_ffff_0000,
        112'h0000_0010_3012_004f_1d1f_8000_0000,
        112'hffff_0010_3112_004f_1d1f_7fff_0000,
        112'h0001_0000_3412_0000_1d1f_0000_0000,
        112'h0000_0001_3412_0100_1d1f_0001_0000,
        112'h0001_0001_3412_0200_1d1f_0000_0000,
        112'h1234_0000_3810_f0ab_1d1f_12a4_0000,
        112'h1234_0000_3910_f0ab_1d1f_a234_0000,
        112'h0005_0005_3c12_7000_1d1f_0004_0000,
        112'h0005_0005_3d12_7000_1d1f_0003_0000,
        112'h0005_0005_4012_7000_1d1f_0006_0000,
        112'h0005_0005_4112_7000_1d1f_0007_0000,
        112'h1234_0010_4412_7000_1d1f_000b_0000,
        112'h1234_0000_4412_7000_1d1f_0000_0000,
        112'h1234_0000_4814_7000_1d1f_2340_0000,
        112'h1234_0000_4914_7000_1d1f_0123_0000,
        112'h8000_0000_4c14_7000_1d1f_f800_0000,
        112'h1234_0080_5012_7000_1d1f_ff80_0000,
        112'h1234_0080_5112_7000_1d1f_0080_0000,
        112'h5a5a_0000_5402_0002_1d1f_0000_0000,
        112'h5a5a_0000_5482_0002_1d1f_5a5a_0000,
        112'h5a5a_0000_5400_0012_1d1f_0000_0000,
        112'h5a5a_0012_5401_0002_1d1f_0000_0000,
        112'h5a5a_0001_5820_0002_1d1f_0000_0000,
        112'h5a5a_0000_5820_0002_1d1f_5a5a_0000,
        112'h5a5a_0001_5920_0000_1d2f_0000_0000,
        112'h5a5a_0001_5820_0000_1d2f_0001_0000,
        112'h1234_0000_5c10_0020_1d3f_1234_0000,
        112'h1234_0000_600a_7000_1d1f_1234_0000,
        112'h1234_0000_6410_4321_1d1f_4321_0000
    };

    cpu_instruction_set_core DUT (
        .clk(clk), .reset(reset), .progData(progData), .progValid(progValid), .progRd_q(progRd_q),
        .progAddr_q(progAddr_q), .pc_q(pc_q), .flags_q(flags_q), .mdh_q(mdh_q), .mdl_q(mdl_q),
        .pageActive_q(pageActive_q), .pageNum_q(pageNum_q), .extReg_q(extReg_q), .trapTaken_q(trapTaken_q)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // program memory; released bus shows inverted data so stale reads stand out
    always @(posedge clk) begin
        lag <= (progRd_q && !progValid) ? lag + 1 : 0;
        progValid <= progRd_q && !progValid && lag >= dly;
        progData <= progRd_q ? rom[progAddr_q[5:1]] : ~progData;
    end

    task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
        numChecks++;
        if (g !== e) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic closeOut;
        if (errorCnt == 0 && numChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // program held in reset while loaded, so no half-written code runs
    task automatic setRow(logic [111:0] r);
        @(posedge clk);
        reset <= 1'b1;
        {a, b, w6, w7, ck, em, eh} = r;
        rom[1] = a;
        rom[3] = b;
        rom[6] = w6;
        rom[7] = w7;
        rom[8] = ck;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic runTo;
        p = 0;
        while (pc_q !== 16'h0012 && p < 500) begin
            @(posedge clk);
            p++;
        end
        cmp("halt address", 16'h0012, pc_q);
    endtask

    task automatic pageCase(logic [111:0] r, logic [15:0] pg, logic [15:0] ext, bit midReset);
        setRow(r);
        p = 0;
        while (pageActive_q !== 1'b1 && p < 200) begin
            @(posedge clk);
            p++;
        end
        cmp("page number", pg, {6'h00, pageNum_q});
        cmp("register extension", ext, {15'h0000, extReg_q});
        if (midReset) begin
            reset <= 1'b1;
            repeat (2) @(posedge clk);
            cmp("page after reset", 16'h0000, {15'h0000, pageActive_q});
            cmp("pc after reset", 16'h0000, pc_q);
            cmp("flags after reset", 16'h0000, {12'h000, flags_q});
        end else begin
            runTo();
            repeat (8) @(posedge clk);
            cmp("page expired", 16'h0000, {15'h0000, pageActive_q});
        end
    endtask

    initial begin
        reset = 1'b1;
        progValid = 1'b0;
        progData = 16'h0000;
        lag = 0;
        dly = 0;
        foreach (rom[k]) rom[k] = 16'h7000;
        rom[0] = 16'h7610;
        rom[2] = 16'h7620;
        rom[4] = 16'h76f0;
        rom[5] = 16'h0001;
        rom[9] = 16'h5400;
        rom[10] = 16'h0012;
        rom[16] = 16'h6930;
        rom[20] = 16'h6800;
        repeat (16) @(posedge clk);
        // second pass with a slow memory
        for (int pass = 0; pass < 2; pass++) begin
            dly = pass * 2;
            foreach (rows[i]) begin
                setRow(rows[i]);
                runTo();
                cmp("muldiv low", em, mdl_q);
                cmp("muldiv high", eh, mdh_q);
            end
        end
        // divide by zero leaves the pair alone and flags overflow
        setRow(112'h0064_0000_1d1f_2102_7000_0064_0000);
        runTo();
        cmp("zero divide low", 16'h0064, mdl_q);
        cmp("overflow flag", 16'h0001, {15'h0000, flags_q[3]});
        pageCase(112'h1234_0000_6f00_0155_1d1f_1234_0000, 16'h0155, 16'h0001, 1'b1);
        pageCase(112'h1234_02aa_6c12_7000_1d1f_1234_0000, 16'h02aa, 16'h0000, 1'b0);
        closeOut();
    end

    initial begin
        repeat (50000) @(posedge clk);
        errorCnt++;
        closeOut();
    end
endmodule // cpu_instruction_set_core_tb_top
